//--- pkg/fwlf_pkg.sv
// Constants, types and helpers of the field weakening and lock fault config block.
// Assumes one 200 MHz clock and an APB master with 32-bit data.
// How it works
// - Control bit 6 enables max torque per amp
// - Bits 5-4 pick modulation target 70-95 percent
// - Bits 3-1 cap weakening current, 80-20 percent
// - Cap code zero means circular limit only
// - Control bit 0 enables flux weakening
// - Bits 5-2 pick retry interval, 100ms-14s
// - Mode 0 latches lock fault, drives fault low
// - Mode 1 fault clears after retry interval
// - Mode 2 only reports a lock
// - Mode 3 sets no fault or report, status bit 3 still shows lock_detect
// - Config registers reset to zero
package fwlf_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int FC_W   = 7;
  localparam int MS_W   = 14;
  localparam int PCT_W  = 7;

  typedef logic [DATA_W-1:0] fwlf_word_t;
  typedef logic [ADDR_W-1:0] fwlf_addr_t;
  typedef logic [PCT_W-1:0]  fwlf_pct_t;
  typedef logic [MS_W-1:0]   fwlf_ms_t;

  // Byte addresses
  localparam fwlf_addr_t OFS_FIELD_CTRL  = 12'h04c;
  localparam fwlf_addr_t OFS_LOCK_CFG    = 12'h050;
  localparam fwlf_addr_t OFS_LOCK_STATUS = 12'h060;

  // Reset values
  localparam logic [FC_W-1:0] FIELD_CTRL_RST = 7'h00;
  localparam fwlf_word_t      LOCK_CFG_RST   = 32'h0000_0000;

  // Field control layout
  localparam int FC_FW_EN_BIT = 0;
  localparam int FC_CAP_LSB   = 1;
  localparam int FC_CAP_W     = 3;
  localparam int FC_MOD_LSB   = 4;
  localparam int FC_MOD_W     = 2;
  localparam int FC_MAX_TORQUE_PER_AMP_BIT  = 6;

  // Lock config layout
  localparam int LC_MODE_LSB  = 0;
  localparam int LC_MODE_W    = 2;
  localparam int LC_RETRY_LSB = 2;
  localparam int LC_RETRY_W   = 4;

  // Lock status layout
  localparam int ST_FAULT_BIT  = 0;
  localparam int ST_REPORT_BIT = 1;
  localparam int ST_RETRY_BIT  = 2;
  localparam int ST_DETECT_BIT = 3;

  typedef enum logic [1:0] {
    FWLF_LATCH  = 2'b00,
    FWLF_AUTO   = 2'b01,
    FWLF_REPORT = 2'b10,
    FWLF_OFF    = 2'b11
  } fwlf_mode_t;

  // Timing
  localparam int CLK_FREQ_KHZ  = 200000;
  localparam int MS_UNIT       = 1;
  localparam int CYCLES_PER_MS = CLK_FREQ_KHZ * MS_UNIT;
  localparam fwlf_ms_t RETRY_FIRST_MS  = 14'h0064;
  localparam fwlf_ms_t RETRY_SECOND_MS = 14'h01f4;
  localparam fwlf_ms_t RETRY_STEP_MS   = 14'h03e8;

  // Percent tables
  localparam fwlf_pct_t MOD_PCT_0    = 7'h46;
  localparam fwlf_pct_t MOD_PCT_1    = 7'h50;
  localparam fwlf_pct_t MOD_PCT_2    = 7'h5a;
  localparam fwlf_pct_t MOD_PCT_3    = 7'h5f;
  localparam fwlf_pct_t CAP_PCT_TOP  = 7'h5a;
  localparam fwlf_pct_t CAP_PCT_STEP = 7'h0a;
  localparam fwlf_pct_t PCT_NONE     = 7'h00;

  function automatic fwlf_pct_t mod_index_pct(input logic [FC_MOD_W-1:0] code);
    unique case (code)
      2'h0: mod_index_pct = MOD_PCT_0;
      2'h1: mod_index_pct = MOD_PCT_1;
      2'h2: mod_index_pct = MOD_PCT_2;
      2'h3: mod_index_pct = MOD_PCT_3;
    endcase
  endfunction : mod_index_pct

  function automatic fwlf_pct_t cap_pct(input logic [FC_CAP_W-1:0] code);
    if (code == 3'h0) begin
      cap_pct = PCT_NONE;
    end else begin
      cap_pct = PCT_W'(CAP_PCT_TOP - CAP_PCT_STEP * {4'h0, code});
    end
  endfunction : cap_pct

  function automatic fwlf_ms_t retry_ms(input logic [LC_RETRY_W-1:0] code);
    if (code == 4'h0) begin
      retry_ms = RETRY_FIRST_MS;
    end else if (code == 4'h1) begin
      retry_ms = RETRY_SECOND_MS;
    end else begin
      retry_ms = MS_W'(RETRY_STEP_MS * ({10'h000, code} - 14'h0001));
    end
  endfunction : retry_ms
endpackage : fwlf_pkg

//--- pkg/fwlf_retry_if.sv
// Link between the lock control and the retry timer.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface fwlf_retry_if;
  logic               start;
  fwlf_pkg::fwlf_ms_t interval_ms;
  logic               expire;
  logic               active;

  modport ctrl  (output start, output interval_ms, input expire, input active);
  modport timer (input start, input interval_ms, output expire, output active);
endinterface : fwlf_retry_if

//--- rtl/fwlf_retry_timer.sv
// Lock retry timer: millisecond prescaler and millisecond down counter.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/100ps
module fwlf_retry_timer #(
  parameter int MS_CYCLES = fwlf_pkg::CYCLES_PER_MS
) (
  input  wire logic   clk,
  input  wire logic   reset_n,
  fwlf_retry_if.timer rt
);
  import fwlf_pkg::*;

  localparam int PRE_W = $clog2(MS_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);

  if (MS_CYCLES < 1) begin : g_bad
    $error("MS_CYCLES must be at least one");
  end

  logic [PRE_W-1:0] pre_reg;
  fwlf_ms_t         left_reg;
  logic             active_reg;
  logic             expire_reg;

  // Interval latched at start, counted in whole milliseconds
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg    <= '0;
      left_reg   <= '0;
      active_reg <= 1'b0;
      expire_reg <= 1'b0;
    end else if (rt.start) begin
      pre_reg    <= '0;
      left_reg   <= rt.interval_ms;
      active_reg <= 1'b1;
      expire_reg <= 1'b0;
    end else if (active_reg && pre_reg == PRE_LAST) begin
      pre_reg    <= '0;
      left_reg   <= MS_W'(left_reg - 14'h0001);
      active_reg <= left_reg != 14'h0001;
      expire_reg <= left_reg == 14'h0001;
    end else begin
      pre_reg    <= active_reg ? PRE_W'(pre_reg + 1'b1) : pre_reg;
      expire_reg <= 1'b0;
    end
  end

  assign rt.active = active_reg;
  assign rt.expire = expire_reg;

  // Cycle count since start, for checking only
  logic [39:0] run_reg;
  logic [39:0] want_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_reg  <= '0;
      want_reg <= '0;
    end else if (rt.start) begin
      run_reg  <= 40'h00_0000_0001;
      want_reg <= 40'(rt.interval_ms) * 40'(MS_CYCLES);
    end else begin
      run_reg  <= 40'(run_reg + 1'b1);
    end
  end

  property p_retry_len;
    @(posedge clk) disable iff (!reset_n)
    rt.expire |-> run_reg == want_reg + 40'h00_0000_0001;
  endproperty
  a_retry_len: assert property (p_retry_len)
    else $error("Retry interval length wrong");
endmodule : fwlf_retry_timer

//--- rtl/fwlf_top.sv
// Field weakening control and lock fault configuration with APB access.
// Assumes lock_detect comes from the lock detector on the same clock.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
module fwlf_top #(
  parameter int MS_CYCLES = fwlf_pkg::CYCLES_PER_MS
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire fwlf_pkg::fwlf_addr_t paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire fwlf_pkg::fwlf_word_t pwdata,
  output logic                     pready,
  output fwlf_pkg::fwlf_word_t     prdata,
  output logic                     pslverr,
  input  wire logic                lock_detect,
  output logic                     max_torque_per_amp_enable,
  output logic                     weakening_enable,
  output fwlf_pkg::fwlf_pct_t      mod_index_target_pct,
  output fwlf_pkg::fwlf_pct_t      weakening_current_cap,
  output logic                     weakening_cap_active,
  output logic                     lock_fault,
  output logic                     lock_reported,
  output logic                     fault_out_n
);
  import fwlf_pkg::*;

  if (MS_CYCLES < 1) begin : g_bad
    $error("MS_CYCLES must be at least one");
  end

  fwlf_retry_if rt ();

  fwlf_retry_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .rt      (rt.timer)
  );

  logic [FC_W-1:0] field_ctrl_reg;
  fwlf_word_t      lock_cfg_reg;
  fwlf_word_t      prdata_reg;
  logic            pready_reg;
  logic            pslverr_reg;
  logic            fault_reg;
  logic            reported_reg;
  logic            fault_n_reg;
  logic            max_torque_per_amp_reg;
  logic            fw_en_reg;
  fwlf_pct_t       mod_pct_reg;
  fwlf_pct_t       cap_pct_reg;
  logic            cap_act_reg;

  // Bus decode
  logic       setup;
  logic       wr;
  logic       sel_fc;
  logic       sel_lc;
  logic       sel_st;
  logic       hit;
  fwlf_word_t status_word;
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pready_reg && pwrite && !pslverr_reg;
  assign sel_fc = paddr == OFS_FIELD_CTRL;
  assign sel_lc = paddr == OFS_LOCK_CFG;
  assign sel_st = paddr == OFS_LOCK_STATUS;
  assign hit    = sel_fc || sel_lc || sel_st;

  always_comb begin
    status_word                = '0;
    status_word[ST_FAULT_BIT]  = fault_reg;
    status_word[ST_REPORT_BIT] = reported_reg;
    status_word[ST_RETRY_BIT]  = rt.active;
    status_word[ST_DETECT_BIT] = lock_detect;
  end

  // No wait state: answer prepared in setup, given in the first access cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !hit;
      if (setup && !pwrite) begin
        if (sel_fc) begin
          prdata_reg <= DATA_W'(field_ctrl_reg);
        end else if (sel_lc) begin
          prdata_reg <= lock_cfg_reg;
        end else if (sel_st) begin
          prdata_reg <= status_word;
        end else begin
          prdata_reg <= '0;
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      field_ctrl_reg <= FIELD_CTRL_RST;
      lock_cfg_reg   <= LOCK_CFG_RST;
    end else if (wr) begin
      if (sel_fc) begin
        field_ctrl_reg <= pwdata[FC_W-1:0];
      end
      if (sel_lc) begin
        lock_cfg_reg <= pwdata;
      end
    end
  end

  // Field control outputs
  logic [FC_CAP_W-1:0] cap_code;
  logic [FC_MOD_W-1:0] mod_code;
  assign cap_code = field_ctrl_reg[FC_CAP_LSB +: FC_CAP_W];
  assign mod_code = field_ctrl_reg[FC_MOD_LSB +: FC_MOD_W];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      max_torque_per_amp_reg    <= 1'b0;
      fw_en_reg   <= 1'b0;
      mod_pct_reg <= MOD_PCT_0;
      cap_pct_reg <= PCT_NONE;
      cap_act_reg <= 1'b0;
    end else begin
      max_torque_per_amp_reg    <= field_ctrl_reg[FC_MAX_TORQUE_PER_AMP_BIT];
      fw_en_reg   <= field_ctrl_reg[FC_FW_EN_BIT];
      mod_pct_reg <= mod_index_pct(mod_code);
      cap_pct_reg <= cap_pct(cap_code);
      cap_act_reg <= cap_code != 3'h0;
    end
  end

  // Lock handling
  fwlf_mode_t mode;
  logic       det_on;
  logic       fault_set;
  logic       sw_clr_fault;
  logic       sw_clr_report;
  logic       timer_clr;
  logic       fault_next;
  assign mode          = fwlf_mode_t'(lock_cfg_reg[LC_MODE_LSB +: LC_MODE_W]);
  assign sw_clr_fault  = wr && sel_st && pwdata[ST_FAULT_BIT];
  assign sw_clr_report = wr && sel_st && pwdata[ST_REPORT_BIT];
  assign timer_clr     = rt.expire && mode == FWLF_AUTO;

  always_comb begin
    unique case (mode)
      FWLF_LATCH:  begin
        det_on    = 1'b1;
        fault_set = lock_detect;
      end
      FWLF_AUTO:   begin
        det_on    = 1'b1;
        fault_set = lock_detect;
      end
      FWLF_REPORT: begin
        det_on    = 1'b1;
        fault_set = 1'b0;
      end
      FWLF_OFF:    begin
        det_on    = 1'b0;
        fault_set = 1'b0;
      end
    endcase
  end

  // Set wins over any clear
  always_comb begin
    if (fault_set) begin
      fault_next = 1'b1;
    end else if (sw_clr_fault || timer_clr) begin
      fault_next = 1'b0;
    end else begin
      fault_next = fault_reg;
    end
  end

  // Timer restarts while locked or while an auto fault waits
  assign rt.start       = mode == FWLF_AUTO && !rt.active
                          && (lock_detect || (fault_reg && !rt.expire));
  assign rt.interval_ms = retry_ms(lock_cfg_reg[LC_RETRY_LSB +: LC_RETRY_W]);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_reg   <= 1'b0;
      fault_n_reg <= 1'b1;
    end else begin
      fault_reg   <= fault_next;
      fault_n_reg <= !fault_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reported_reg <= 1'b0;
    end else if (det_on && lock_detect) begin
      reported_reg <= 1'b1;
    end else if (sw_clr_report) begin
      reported_reg <= 1'b0;
    end
  end

  assign pready                    = pready_reg;
  assign prdata                    = prdata_reg;
  assign pslverr                   = pslverr_reg;
  assign max_torque_per_amp_enable = max_torque_per_amp_reg;
  assign weakening_enable          = fw_en_reg;
  assign mod_index_target_pct      = mod_pct_reg;
  assign weakening_current_cap     = cap_pct_reg;
  assign weakening_cap_active      = cap_act_reg;
  assign lock_fault                = fault_reg;
  assign lock_reported             = reported_reg;
  assign fault_out_n               = fault_n_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_fc_write;
    wr && sel_fc;
  endsequence

  property p_max_torque_per_amp;
    s_fc_write |-> ##2 max_torque_per_amp_enable == $past(pwdata[FC_MAX_TORQUE_PER_AMP_BIT], 2);
  endproperty
  a_max_torque_per_amp: assert property (p_max_torque_per_amp)
    else $error("Max torque per amp enable does not follow write");

  property p_mod_pct;
    mod_index_target_pct == mod_index_pct($past(mod_code));
  endproperty
  a_mod_pct: assert property (p_mod_pct)
    else $error("Modulation target does not match code");

  property p_cap_pct;
    $past(cap_code) != 3'h0 |-> weakening_cap_active
      && weakening_current_cap + CAP_PCT_STEP * {4'h0, $past(cap_code)} == CAP_PCT_TOP;
  endproperty
  a_cap_pct: assert property (p_cap_pct)
    else $error("Weakening current cap wrong");

  property p_cap_none;
    cap_code == 3'h0 |=> !weakening_cap_active && weakening_current_cap == PCT_NONE;
  endproperty
  a_cap_none: assert property (p_cap_none)
    else $error("Cap applied with code zero");

  property p_fw_en;
    s_fc_write |-> ##2 weakening_enable == $past(pwdata[FC_FW_EN_BIT], 2);
  endproperty
  a_fw_en: assert property (p_fw_en)
    else $error("Flux weakening enable does not follow write");

  property p_retry_load;
    rt.start |-> rt.interval_ms == retry_ms(lock_cfg_reg[LC_RETRY_LSB +: LC_RETRY_W]);
  endproperty
  a_retry_load: assert property (p_retry_load)
    else $error("Retry interval not taken from config");

  sequence s_latch_hold;
    mode == FWLF_LATCH && (lock_detect || (fault_reg && !sw_clr_fault));
  endsequence

  property p_latch;
    s_latch_hold
      |=> lock_fault && !fault_out_n ##1 fault_out_n == !lock_fault;
  endproperty
  a_latch: assert property (p_latch)
    else $error("Latched lock fault not held");

  property p_auto_clear;
    mode == FWLF_AUTO && rt.expire && !lock_detect |=> !lock_fault && fault_out_n;
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("Auto fault not cleared at expiry");

  property p_report;
    mode == FWLF_REPORT && lock_detect && !fault_reg |=> lock_reported && !lock_fault;
  endproperty
  a_report: assert property (p_report)
    else $error("Report mode raised a fault");

  property p_off;
    mode == FWLF_OFF && !reported_reg && !fault_reg |=> !lock_reported && !lock_fault;
  endproperty
  a_off: assert property (p_off)
    else $error("Detection active in disabled mode");

  property p_reset_val;
    $rose(reset_n) |-> field_ctrl_reg == FIELD_CTRL_RST && lock_cfg_reg == LOCK_CFG_RST
      && fault_out_n;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("Registers not zero after reset");

  property p_timer_start;
    mode == FWLF_AUTO && lock_detect && !fault_reg && !rt.active
      |-> rt.start ##1 (rt.active && lock_fault) [*2];
  endproperty
  a_timer_start: assert property (p_timer_start)
    else $error("Retry timer not started with auto fault");
endmodule : fwlf_top

//--- sim/fwlf_stall_src.sv
// Partner: lock detector feeding the block, power stage watching the fault pin.
// Assumes the same clock and reset as the block.
`timescale 1ns/100ps
module fwlf_stall_src (
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  stall_req,
  input  wire logic  fault_out_n,
  output logic       lock_detect,
  output logic [7:0] trip_count
);
  logic pin_q;

  // Detector output, level on the same clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_detect <= 1'b0;
    end else begin
      lock_detect <= stall_req;
    end
  end

  // Power stage counts each fault assertion
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_q      <= 1'b1;
      trip_count <= 8'h00;
    end else begin
      pin_q <= fault_out_n;
      if (pin_q && !fault_out_n) begin
        trip_count <= trip_count + 8'h01;
      end
    end
  end
endmodule : fwlf_stall_src

//--- sim/fwlf_tb_top.sv
// Self-checking bench of the field weakening and lock fault block.
// Assumes MS_CYCLES shortened to 2 so retry intervals stay short.
`timescale 1ns/100ps
module fwlf_tb_top;
  import fwlf_pkg::*;
  localparam int MSC = 2;
  logic       clk       = 1'b0;
  logic       reset_n   = 1'b0;
  fwlf_addr_t paddr     = '0;
  logic       psel      = 1'b0;
  logic       penable   = 1'b0;
  logic       pwrite    = 1'b0;
  fwlf_word_t pwdata    = '0;
  logic       stall_req = 1'b0;
  logic       pready, pslverr, lock_detect, max_torque_per_amp, fw_en, cap_act, flt, rep, flt_n;
  fwlf_word_t prdata, rd;
  fwlf_pct_t  mod_o, cap_o;
  logic [7:0] trips;
  logic       er;
  int         err_total = 0;
  int         compares  = 0;

  always #2.5 clk = ~clk;

  fwlf_top #(.MS_CYCLES(MSC)) fwlf_top_i (
    .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .lock_detect(lock_detect), .max_torque_per_amp_enable(max_torque_per_amp), .weakening_enable(fw_en),
    .mod_index_target_pct(mod_o), .weakening_current_cap(cap_o),
    .weakening_cap_active(cap_act), .lock_fault(flt), .lock_reported(rep), .fault_out_n(flt_n)
  );

  fwlf_stall_src fwlf_stall_src_i (
    .clk(clk), .reset_n(reset_n), .stall_req(stall_req), .fault_out_n(flt_n),
    .lock_detect(lock_detect), .trip_count(trips)
  );

  task automatic chk(input fwlf_word_t seen, input fwlf_word_t exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("Counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input fwlf_addr_t a, input fwlf_word_t d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    if (n >= 40) begin
      err_total++;
      $display("[FAIL] %0t bus hang", $time);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdchk(input fwlf_addr_t a, input fwlf_word_t exp, input logic eexp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, eexp});
  endtask : rdchk

  task automatic stall(input int n);
    stall_req <= 1'b1;
    repeat (n) @(posedge clk);
    stall_req <= 1'b0;
  endtask : stall

  task automatic wait_flt(input logic lvl, input int lim, output int n);
    n = 0;
    while (flt !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_flt

  task automatic t_reset;
    chk({25'h0, mod_o}, 32'h46);
    chk({19'h0, cap_o, cap_act, max_torque_per_amp, fw_en, flt, rep, flt_n}, 32'h1);
    rdchk(OFS_FIELD_CTRL, 32'h0, 1'b0);
    rdchk(OFS_LOCK_CFG, 32'h0, 1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_field;
    fwlf_pct_t  mt [4] = '{7'h46, 7'h50, 7'h5a, 7'h5f};
    logic [6:0] v;
    fwlf_pct_t  c;
    for (int i = 0; i < 128; i++) begin
      v = 7'(i);
      c = (v[3:1] == 3'h0) ? 7'h00 : 7'h5a - 7'h0a * {4'h0, v[3:1]};
      apb(1'b1, OFS_FIELD_CTRL, {25'h1ff_ffff, v});
      @(posedge clk);
      chk({31'h0, max_torque_per_amp}, {31'h0, v[6]});
      chk({25'h0, mod_o}, {25'h0, mt[v[5:4]]});
      chk({25'h0, cap_o}, {25'h0, c});
      chk({31'h0, cap_act}, {31'h0, |v[3:1]});
      chk({31'h0, fw_en}, {31'h0, v[0]});
      rdchk(OFS_FIELD_CTRL, {25'h0, v}, 1'b0);
    end
    $display("test field done");
  endtask : t_field

  task automatic t_cfg;
    apb(1'b1, OFS_LOCK_CFG, 32'hdead_beec);
    rdchk(OFS_LOCK_CFG, 32'hdead_beec, 1'b0);
    apb(1'b1, 12'h058, 32'hffff_ffff);
    rdchk(12'h058, 32'h0, 1'b1);
    rdchk(OFS_LOCK_CFG, 32'hdead_beec, 1'b0);
    $display("test config done");
  endtask : t_cfg

  task automatic t_latch;
    int         n;
    logic [7:0] t0;
    apb(1'b1, OFS_LOCK_CFG, 32'h0);
    t0 = trips;
    stall(2);
    wait_flt(1'b1, 10, n);
    repeat (30) @(posedge clk);
    chk({30'h0, flt, flt_n}, 32'h2);
    chk({24'h0, trips}, {24'h0, t0 + 8'h01});
    apb(1'b1, OFS_LOCK_STATUS, 32'h1);
    @(posedge clk);
    chk({30'h0, flt, flt_n}, 32'h1);
    $display("test latch done");
  endtask : t_latch

  task automatic t_auto;
    logic [3:0] cd [4] = '{4'h0, 4'h1, 4'h2, 4'hf};
    int         ms, n, lim;
    logic [7:0] t0;
    foreach (cd[i]) begin
      ms  = (cd[i] == 4'h0) ? 100 : (cd[i] == 4'h1) ? 500 : (int'(cd[i]) - 1) * 1000;
      lim = ms * MSC;
      apb(1'b1, OFS_LOCK_CFG, {26'h0, cd[i], 2'h1});
      t0 = trips;
      stall(1);
      wait_flt(1'b1, 10, n);
      chk({31'h0, flt_n}, 32'h0);
      wait_flt(1'b0, lim + 50, n);
      chk({31'h0, n >= lim - 3 && n <= lim + 3}, 32'h1);
      chk({31'h0, flt_n}, 32'h1);
      chk({24'h0, trips}, {24'h0, t0 + 8'h01});
    end
    $display("test auto done");
  endtask : t_auto

  task automatic t_report;
    apb(1'b1, OFS_LOCK_CFG, 32'h2);
    apb(1'b1, OFS_LOCK_STATUS, 32'h2);
    chk({31'h0, rep}, 32'h0);
    stall(2);
    repeat (4) @(posedge clk);
    chk({29'h0, rep, flt, flt_n}, 32'h5);
    rdchk(OFS_LOCK_STATUS, 32'h2, 1'b0);
    apb(1'b1, OFS_LOCK_STATUS, 32'h2);
    @(posedge clk);
    chk({31'h0, rep}, 32'h0);
    $display("test report done");
  endtask : t_report

  task automatic t_off;
    logic [7:0] t0;
    t0 = trips;
    apb(1'b1, OFS_LOCK_CFG, 32'h3);
    stall_req <= 1'b1;
    @(posedge clk);
    rdchk(OFS_LOCK_STATUS, 32'h8, 1'b0);
    stall(4);
    repeat (4) @(posedge clk);
    chk({29'h0, rep, flt, flt_n}, 32'h1);
    chk({24'h0, trips}, {24'h0, t0});
    $display("test off done");
  endtask : t_off

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    t_reset();
    t_field();
    t_cfg();
    t_latch();
    t_auto();
    t_report();
    t_off();
    close_out();
  end

  initial begin
    #400000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end
endmodule : fwlf_tb_top
